// ==== hdl/ppm_pkg.sv ====
// How it works
// - direction 0 without alternate owner drives the latch bit; analog enable leaves it alone
// - direction 1 reads pin level; analog enabled pins read as zero
// - routed comparator outputs override latch data on port A bits 4 and 5 when those bits are set as outputs
// - clock-out oscillator modes drive the cycle clock, oscillator over four, on bit 6
// - port A bit 6 is general I/O only in three I/O modes, else reads zero
// - port B bits 6 and 7 as inputs get pull-ups while pull-up control is low
// - programming or debug mode disables every other function on its two pins
// - tool drives clock into port B bit 6; bit 7 carries data both ways
// - port B analog pins come up analog when the analog default strap is set
// - second capture/compare signal uses alternate pin when route strap is zero
// - port A bits 3 and 5 reset to analog channels 3 and 4
// - port A bit 5 feeds serial slave select when its direction is input
// - port A bit 4 feeds the transceiver receive input regardless of direction
package ppm_pkg;

	// ============================================================
	// register map (byte addresses)
	localparam int unsigned APB_AW         = 8;
	localparam logic [7:0]  ADDR_PA_LATCH  = 8'h00;
	localparam logic [7:0]  ADDR_PA_DIR    = 8'h04;
	localparam logic [7:0]  ADDR_PB_LATCH  = 8'h08;
	localparam logic [7:0]  ADDR_PB_DIR    = 8'h0C;
	localparam logic [7:0]  ADDR_CONTROL   = 8'h10;
	localparam logic [7:0]  ADDR_PIN_READ  = 8'h14;
	localparam logic [7:0]  ADDR_CONFIG    = 8'h18;

	// ============================================================
	// field layouts
	localparam int unsigned PA_LO          = 3;
	localparam int unsigned PA_W           = 4;
	localparam int unsigned PB_LO          = 6;
	localparam int unsigned PB_W           = 2;
	localparam int unsigned RD_PB_LO       = 14;
	localparam int unsigned CTL_PULLUP_N   = 0;
	localparam int unsigned CTL_CMP1_ROUTE = 1;
	localparam int unsigned CTL_CMP2_ROUTE = 2;
	localparam int unsigned CTL_USB_XCVR   = 3;
	localparam int unsigned CTL_AN3        = 4;
	localparam int unsigned CTL_AN4        = 5;
	localparam int unsigned CTL_PBAN_LO    = 8;
	localparam int unsigned PB_AN_W_DEF    = 5;
	localparam int unsigned CFG_OSC_LO     = 0;
	localparam int unsigned CFG_PIN_READ_B_ANALOG_DEFAULT     = 4;
	localparam int unsigned CFG_CCP_ROUTE  = 5;
	localparam int unsigned CFG_DEBUG      = 6;
	// index of each pin inside its port A or port B vector
	localparam int unsigned IA3            = 0;
	localparam int unsigned IA4            = 1;
	localparam int unsigned IA5            = 2;
	localparam int unsigned IA6            = 3;
	localparam int unsigned IB6            = 0;
	localparam int unsigned IB7            = 1;

	// ============================================================
	// reset values and the alternate route code
	localparam logic [3:0]  RST_PA_LATCH   = 4'h0;
	localparam logic [3:0]  RST_PA_DIR     = 4'hF;
	localparam logic [1:0]  RST_PB_LATCH   = 2'h0;
	localparam logic [1:0]  RST_PB_DIR     = 2'h3;
	localparam logic        RST_PULLUP_N   = 1'b1;
	localparam logic        RST_ANALOG_A   = 1'b1;
	localparam logic        ROUTE_ALT      = 1'b0;

	// ============================================================
	// timing: cycle clock is the core clock over four
	localparam int unsigned CYC_DIV        = 4;
	localparam int unsigned DIV_W          = $clog2(CYC_DIV);

	// ============================================================
	// oscillator modes (codes are the strap encoding)
	typedef enum logic [2:0] {
		OSC_CRYSTAL            = 3'h0,
		OSC_EXT_CLOCK          = 3'h1,
		OSC_EXT_CLOCK_IO       = 3'h2,
		OSC_EXT_CLOCK_PLL      = 3'h3,
		OSC_EXT_CLOCK_PLL_IO   = 3'h4,
		OSC_INT_OSC_IO         = 3'h5,
		OSC_INT_OSC_CLOCKOUT   = 3'h6,
		OSC_RESERVED           = 3'h7
	} ppm_osc_e;

	// ============================================================
	// pin drive carriers
	typedef struct packed {
		logic [PA_W-1:0] out;
		logic [PA_W-1:0] oe;
	} ppm_drive_a_s;

	typedef struct packed {
		logic [PB_W-1:0] out;
		logic [PB_W-1:0] oe;
		logic [PB_W-1:0] pull;
	} ppm_drive_b_s;

	typedef struct packed {
		logic out;
		logic oe;
	} ppm_pin_s;

endpackage

// ==== hdl/ppm_sync.sv ====
`timescale 1ns/1ns
// ============================================================
// two-flop synchroniser, one stage pair per bit
module ppm_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;

	// first stage is read only by the second stage
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				meta_r[i] <= 1'b0;
				q[i]      <= 1'b0;
			end else begin
				meta_r[i] <= d[i];
				q[i]      <= meta_r[i];
			end
		end
	end
endmodule

// ==== hdl/ppm_top.sv ====
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module ppm_top
	import ppm_pkg::*;
#(
	parameter int unsigned PB_AN_W = PB_AN_W_DEF
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [APB_AW-1:0]  paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire ppm_osc_e           osc_mode_cfg,
	input  wire logic               pin_read_b_analog_default,
	input  wire logic               ccp_two_route_select,
	input  wire logic               prog_debug_enable,
	input  wire logic [PA_W-1:0]    pa_in,
	output ppm_drive_a_s            pa_drive,
	input  wire logic [PB_W-1:0]    pb_in,
	output ppm_drive_b_s            pb_drive,
	input  wire logic               comparator_one_output,
	input  wire logic               comparator_two_output,
	input  wire logic               capture_compare_two_out,
	input  wire logic               capture_compare_two_oe,
	input  wire logic               prog_data_out,
	input  wire logic               prog_data_oe,
	output ppm_pin_s                ccp_two_alt_pin,
	output ppm_pin_s                ccp_two_default_pin,
	output logic                    timer_zero_clock_in,
	output logic                    transceiver_receive_in,
	output logic                    ssp_slave_select_n,
	output logic                    change_interrupt_two,
	output logic                    change_interrupt_three,
	output logic                    program_clock_in,
	output logic                    program_data_in,
	output logic [1:0]              analog_select_a,
	output logic                    comparator_one_pos_pin,
	output logic [PB_AN_W-1:0]      pin_read_b_analog_en
);

	// ============================================================
	// pin and debug-enable synchronisers
	logic [PA_W-1:0]    pa_s;
	logic [PB_W-1:0]    pb_s;
	logic               dbg_s;

	ppm_sync #(.WIDTH(PA_W + PB_W + 1)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({prog_debug_enable, pb_in, pa_in}),
		.q       ({dbg_s, pb_s, pa_s})
	);

	// ============================================================
	// straps, caught once at the first edge after reset release
	logic               cfg_valid_r;
	ppm_osc_e           osc_r;
	logic               pin_read_b_analog_default_r;
	logic               ccp_route_r;

	// a constant under reset; the strap level is taken by the clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_valid_r <= 1'b0;
			osc_r       <= OSC_CRYSTAL;
			pin_read_b_analog_default_r    <= 1'b0;
			ccp_route_r <= 1'b1;
		end else if (!cfg_valid_r) begin
			cfg_valid_r <= 1'b1;
			osc_r       <= osc_mode_cfg;
			pin_read_b_analog_default_r    <= pin_read_b_analog_default;
			ccp_route_r <= ccp_two_route_select;
		end
	end

	// ============================================================
	// oscillator mode decode
	logic               mode_clkout;
	logic               mode_ra6_io;

	assign mode_clkout = (osc_r == OSC_EXT_CLOCK) || (osc_r == OSC_EXT_CLOCK_PLL)
		|| (osc_r == OSC_INT_OSC_CLOCKOUT);
	assign mode_ra6_io = (osc_r == OSC_EXT_CLOCK_IO) || (osc_r == OSC_EXT_CLOCK_PLL_IO)
		|| (osc_r == OSC_INT_OSC_IO);

	// ============================================================
	// cycle clock divider
	logic [DIV_W-1:0]   div_r;

	// free running; its top bit is the core clock over four
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + DIV_W'(1);
		end
	end

	// ============================================================
	// apb slave
	logic [PA_W-1:0]    pa_lat_r;
	logic [PA_W-1:0]    pa_dir_r;
	logic [PB_W-1:0]    pb_lat_r;
	logic [PB_W-1:0]    pb_dir_r;
	logic               pullup_n_r;
	logic               cmp1_route_r;
	logic               cmp2_route_r;
	logic               usb_xcvr_r;
	logic               an3_r;
	logic               an4_r;
	logic [PB_AN_W-1:0] pban_r;
	logic [PA_W-1:0]    pin_read_a_r;
	logic [PB_W-1:0]    pin_read_b_r;
	logic               pready_r;
	logic               pslverr_r;
	logic [31:0]        prdata_r;
	logic               apb_acc;
	logic               apb_wr;
	logic [31:0]        rd_nxt;
	logic               hit_nxt;

	assign apb_acc = psel && penable;
	assign apb_wr  = apb_acc && pready_r && pwrite;

	// read mux; unmapped addresses answer zero with an error
	always_comb begin
		rd_nxt  = '0;
		hit_nxt = 1'b1;
		if (paddr == ADDR_PA_LATCH) begin
			rd_nxt[PA_LO +: PA_W] = pa_lat_r;
		end else if (paddr == ADDR_PA_DIR) begin
			rd_nxt[PA_LO +: PA_W] = pa_dir_r;
		end else if (paddr == ADDR_PB_LATCH) begin
			rd_nxt[PB_LO +: PB_W] = pb_lat_r;
		end else if (paddr == ADDR_PB_DIR) begin
			rd_nxt[PB_LO +: PB_W] = pb_dir_r;
		end else if (paddr == ADDR_CONTROL) begin
			rd_nxt[CTL_PULLUP_N]            = pullup_n_r;
			rd_nxt[CTL_CMP1_ROUTE]          = cmp1_route_r;
			rd_nxt[CTL_CMP2_ROUTE]          = cmp2_route_r;
			rd_nxt[CTL_USB_XCVR]            = usb_xcvr_r;
			rd_nxt[CTL_AN3]                 = an3_r;
			rd_nxt[CTL_AN4]                 = an4_r;
			rd_nxt[CTL_PBAN_LO +: PB_AN_W]  = pban_r;
		end else if (paddr == ADDR_PIN_READ) begin
			rd_nxt[PA_LO +: PA_W]           = pin_read_a_r;
			rd_nxt[RD_PB_LO +: PB_W]        = pin_read_b_r;
		end else if (paddr == ADDR_CONFIG) begin
			rd_nxt[CFG_OSC_LO +: 3]         = osc_r;
			rd_nxt[CFG_PIN_READ_B_ANALOG_DEFAULT]              = pin_read_b_analog_default_r;
			rd_nxt[CFG_CCP_ROUTE]           = ccp_route_r;
			rd_nxt[CFG_DEBUG]               = dbg_s;
		end else begin
			hit_nxt = 1'b0;
		end
	end

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= '0;
		end else begin
			pready_r  <= apb_acc && !pready_r;
			pslverr_r <= apb_acc && !pready_r && !hit_nxt;
			if (apb_acc && !pready_r && !pwrite) begin
				prdata_r <= rd_nxt;
			end
		end
	end

	// port latch and direction registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pa_lat_r <= RST_PA_LATCH;
			pa_dir_r <= RST_PA_DIR;
			pb_lat_r <= RST_PB_LATCH;
			pb_dir_r <= RST_PB_DIR;
		end else if (apb_wr) begin
			if (paddr == ADDR_PA_LATCH) begin
				pa_lat_r <= pwdata[PA_LO +: PA_W];
			end else if (paddr == ADDR_PA_DIR) begin
				pa_dir_r <= pwdata[PA_LO +: PA_W];
			end else if (paddr == ADDR_PB_LATCH) begin
				pb_lat_r <= pwdata[PB_LO +: PB_W];
			end else if (paddr == ADDR_PB_DIR) begin
				pb_dir_r <= pwdata[PB_LO +: PB_W];
			end
		end
	end

	// control register; port B analog field reloads from the strap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pullup_n_r   <= RST_PULLUP_N;
			cmp1_route_r <= 1'b0;
			cmp2_route_r <= 1'b0;
			usb_xcvr_r   <= 1'b0;
			an3_r        <= RST_ANALOG_A;
			an4_r        <= RST_ANALOG_A;
			pban_r       <= '0;
		end else if (!cfg_valid_r) begin
			pban_r       <= {PB_AN_W{pin_read_b_analog_default}};
		end else if (apb_wr && (paddr == ADDR_CONTROL)) begin
			pullup_n_r   <= pwdata[CTL_PULLUP_N];
			cmp1_route_r <= pwdata[CTL_CMP1_ROUTE];
			cmp2_route_r <= pwdata[CTL_CMP2_ROUTE];
			usb_xcvr_r   <= pwdata[CTL_USB_XCVR];
			an3_r        <= pwdata[CTL_AN3];
			an4_r        <= pwdata[CTL_AN4];
			pban_r       <= pwdata[CTL_PBAN_LO +: PB_AN_W];
		end
	end

	// ============================================================
	// port A drive: alternate outputs first, then the gated latch
	logic [PA_W-1:0]    alt_en;
	logic [PA_W-1:0]    alt_val;
	logic [PA_W-1:0]    gpio_ok;
	logic [PA_W-1:0]    pa_out_r;
	logic [PA_W-1:0]    pa_oe_r;

	// comparators only own a pin set as output; clock-out ignores it
	always_comb begin
		alt_en       = '0;
		alt_val      = '0;
		gpio_ok      = '1;
		alt_en[IA4]  = cmp1_route_r && !pa_dir_r[IA4];
		alt_val[IA4] = comparator_one_output;
		alt_en[IA5]  = cmp2_route_r && !pa_dir_r[IA5];
		alt_val[IA5] = comparator_two_output;
		alt_en[IA6]  = mode_clkout;
		alt_val[IA6] = div_r[DIV_W-1];
		gpio_ok[IA6] = mode_ra6_io;
	end

	for (genvar i = 0; i < PA_W; i++) begin : g_pa
		// analog enable is not looked at: digital output stays intact
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				pa_out_r[i] <= 1'b0;
				pa_oe_r[i]  <= 1'b0;
			end else if (alt_en[i]) begin
				pa_out_r[i] <= alt_val[i];
				pa_oe_r[i]  <= 1'b1;
			end else begin
				pa_out_r[i] <= pa_lat_r[i] && gpio_ok[i];
				pa_oe_r[i]  <= !pa_dir_r[i] && gpio_ok[i];
			end
		end
	end

	assign pa_drive = '{out: pa_out_r, oe: pa_oe_r};

	// ============================================================
	// port B bits 6/7: debug owns both pins when enabled
	logic [PB_W-1:0]    pb_out_r;
	logic [PB_W-1:0]    pb_oe_r;
	logic [PB_W-1:0]    pb_pull_r;

	// clock pin is input only in debug; data pin follows the tool's engine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pb_out_r  <= '0;
			pb_oe_r   <= '0;
			pb_pull_r <= '0;
		end else if (dbg_s) begin
			pb_out_r  <= {prog_data_out, 1'b0};
			pb_oe_r   <= {prog_data_oe, 1'b0};
			pb_pull_r <= '0;
		end else begin
			pb_out_r  <= pb_lat_r;
			pb_oe_r   <= ~pb_dir_r;
			pb_pull_r <= pb_dir_r & {PB_W{!pullup_n_r}};
		end
	end

	assign pb_drive = '{out: pb_out_r, oe: pb_oe_r, pull: pb_pull_r};

	// ============================================================
	// port reads and inputs to peripherals
	logic [PA_W-1:0]    a_dig_off;

	// analog pins and a claimed bit 6 read as zero
	assign a_dig_off = {!mode_ra6_io, an4_r, 1'b0, an3_r};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_read_a_r <= '0;
			pin_read_b_r <= '0;
		end else begin
			pin_read_a_r <= pa_s & ~a_dig_off;
			pin_read_b_r <= dbg_s ? '0 : pb_s;
		end
	end

	// peripheral feeds; debug mode keeps port B functions quiet
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_zero_clock_in    <= 1'b0;
			transceiver_receive_in <= 1'b0;
			ssp_slave_select_n     <= 1'b1;
			change_interrupt_two   <= 1'b0;
			change_interrupt_three <= 1'b0;
			program_clock_in       <= 1'b0;
			program_data_in        <= 1'b0;
		end else begin
			timer_zero_clock_in    <= pa_dir_r[IA4] && pa_s[IA4];
			transceiver_receive_in <= usb_xcvr_r && pa_s[IA4];
			ssp_slave_select_n     <= !pa_dir_r[IA5] || pa_s[IA5];
			change_interrupt_two   <= !dbg_s && pb_dir_r[IB6] && pb_s[IB6];
			change_interrupt_three <= !dbg_s && pb_dir_r[IB7] && pb_s[IB7];
			program_clock_in       <= dbg_s && pb_s[IB6];
			program_data_in        <= dbg_s && pb_s[IB7];
		end
	end

	// analog selects and capture/compare routing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			analog_select_a        <= '0;
			comparator_one_pos_pin <= 1'b0;
			pin_read_b_analog_en        <= '0;
			ccp_two_alt_pin        <= '0;
			ccp_two_default_pin    <= '0;
		end else begin
			analog_select_a        <= {an4_r, an3_r};
			comparator_one_pos_pin <= an3_r;
			pin_read_b_analog_en        <= pban_r;
			if (ccp_route_r == ROUTE_ALT) begin
				ccp_two_alt_pin     <= '{out: capture_compare_two_out,
					oe: capture_compare_two_oe};
				ccp_two_default_pin <= '0;
			end else begin
				ccp_two_alt_pin     <= '0;
				ccp_two_default_pin <= '{out: capture_compare_two_out,
					oe: capture_compare_two_oe};
			end
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;

	// ============================================================
	// assertions
	sequence s_access_start;
		psel && penable && !pready;
	endsequence

	sequence s_access_done;
		##1 (psel && penable && pready);
	endsequence

	a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
		s_access_start |-> s_access_done)
		else $error("apb access not answered after one wait");

	a_latch_drive: assert property (@(posedge pclk) disable iff (!presetn)
		(!pa_dir_r[IA3]) |=> (pa_drive.oe[IA3] && pa_drive.out[IA3] == $past(pa_lat_r[IA3])))
		else $error("port A bit 3 does not follow latch");

	a_analog_reads: assert property (@(posedge pclk) disable iff (!presetn)
		an4_r |=> !pin_read_a_r[IA5])
		else $error("analog pin read as digital");

	a_cmp_override: assert property (@(posedge pclk) disable iff (!presetn)
		(cmp1_route_r && !pa_dir_r[IA4]) |=>
		(pa_drive.oe[IA4] && pa_drive.out[IA4] == $past(comparator_one_output)))
		else $error("comparator one does not own port A bit 4");

	sequence s_clk_high;
		pa_drive.out[IA6] [*2] ##1 !pa_drive.out[IA6];
	endsequence

	a_clkout_rate: assert property (@(posedge pclk) disable iff (!presetn)
		(mode_clkout && $rose(pa_drive.out[IA6])) |-> s_clk_high)
		else $error("cycle clock high time not two core clocks");

	a_ra6_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(!mode_ra6_io && $stable(osc_r)) |=> !pin_read_a_r[IA6])
		else $error("port A bit 6 read while claimed");

	a_pullup_on: assert property (@(posedge pclk) disable iff (!presetn)
		(!dbg_s && !pullup_n_r && pb_dir_r[IB7]) |=> pb_drive.pull[IB7])
		else $error("port B pull-up missing");

	a_debug_isolate: assert property (@(posedge pclk) disable iff (!presetn)
		dbg_s |=> (!pb_drive.oe[IB6] && pb_drive.pull == '0 && !change_interrupt_two))
		else $error("debug pins not isolated");

	a_debug_data: assert property (@(posedge pclk) disable iff (!presetn)
		dbg_s |=> (pb_drive.oe[IB7] == $past(prog_data_oe)
		&& pb_drive.out[IB7] == $past(prog_data_out)))
		else $error("debug data pin not following engine");

	a_pban_default: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(cfg_valid_r) |-> (pban_r == {PB_AN_W{pin_read_b_analog_default_r}}))
		else $error("port B analog default wrong");

	a_ccp_route: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_valid_r && ccp_route_r == ROUTE_ALT) |=>
		(ccp_two_alt_pin.oe == $past(capture_compare_two_oe) && !ccp_two_default_pin.oe))
		else $error("capture compare two misrouted");

	a_analog_reset: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(cfg_valid_r) |-> (an3_r && an4_r))
		else $error("port A analog reset wrong");

	a_slave_select: assert property (@(posedge pclk) disable iff (!presetn)
		(pa_dir_r[IA5]) |=> (ssp_slave_select_n == $past(pa_s[IA5])))
		else $error("slave select not from pin");

	a_xcvr_rcv: assert property (@(posedge pclk) disable iff (!presetn)
		usb_xcvr_r |=> (transceiver_receive_in == $past(pa_s[IA4])))
		else $error("transceiver receive not from pin");

endmodule

// ==== tb/ppm_pins.sv ====
`timescale 1ns/1ns
// ============================================================
// pad model: external levels meet the block's drivers on each pin
module ppm_pins
	import ppm_pkg::*;
(
	input  wire logic            pclk,
	input  wire ppm_drive_a_s    pa_drive,
	input  wire ppm_drive_b_s    pb_drive,
	input  wire logic [PA_W-1:0] ext_a,
	input  wire logic [PB_W-1:0] ext_b,
	input  wire logic            tool_en,
	input  wire logic            tool_clk,
	output logic      [PA_W-1:0] pa_in,
	output logic      [PB_W-1:0] pb_in
);
	logic flip = 1'b0;
	// a released data pad wanders so a stale level never passes
	always @(posedge pclk) flip <= ~flip;
	// driver wins, then the tool, then pull-up, then the far side
	always_comb begin
		pa_in = (pa_drive.oe & pa_drive.out) | (~pa_drive.oe & ext_a);
		for (int i = 0; i < PB_W; i++) begin
			if (pb_drive.oe[i]) pb_in[i] = pb_drive.out[i];
			else if (tool_en && i == IB6) pb_in[i] = tool_clk;
			else if (tool_en) pb_in[i] = flip;
			else if (pb_drive.pull[i]) pb_in[i] = 1'b1;
			else pb_in[i] = ext_b[i];
		end
	end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ns
module tb;
	import ppm_pkg::*;
	typedef struct packed {logic [7:0] lat, dir, ctl; logic [1:0] cmp; logic [7:0] exp;} ppm_row_s;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, tool_en, tool_clk;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	ppm_osc_e osc_mode_cfg;
	logic pin_read_b_analog_default, ccp_two_route_select, prog_debug_enable;
	logic comparator_one_output, comparator_two_output, capture_compare_two_out;
	logic capture_compare_two_oe, prog_data_out, prog_data_oe;
	logic [3:0] pa_in, ext_a;
	logic [1:0] pb_in, ext_b;
	ppm_drive_a_s pa_drive;
	ppm_drive_b_s pb_drive;
	ppm_pin_s ccp_two_alt_pin, ccp_two_default_pin;
	logic timer_zero_clock_in, transceiver_receive_in, ssp_slave_select_n;
	logic change_interrupt_two, change_interrupt_three, program_clock_in, program_data_in;
	logic comparator_one_pos_pin;
	logic [1:0] analog_select_a;
	logic [4:0] pin_read_b_analog_en;
	int n_fail = 0, compares = 0, ones;
	// latch, dir, control, comparators, expected {out&oe, oe}
	ppm_row_s rows [6] = '{'{8'h78, 8'h00, 8'h31, 2'h0, 8'hFF}, '{8'h00, 8'h00, 8'h06, 2'h3, 8'h6F},
		'{8'h78, 8'h00, 8'h06, 2'h0, 8'h9F}, '{8'h78, 8'h78, 8'h00, 2'h3, 8'h00},
		'{8'h28, 8'h50, 8'h00, 2'h0, 8'h55}, '{8'h00, 8'h20, 8'h04, 2'h2, 8'h0B}};

	ppm_top i_ppm_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .osc_mode_cfg, .pin_read_b_analog_default, .ccp_two_route_select,
		.prog_debug_enable, .pa_in, .pa_drive, .pb_in, .pb_drive, .comparator_one_output,
		.comparator_two_output, .capture_compare_two_out, .capture_compare_two_oe,
		.prog_data_out, .prog_data_oe, .ccp_two_alt_pin, .ccp_two_default_pin,
		.timer_zero_clock_in, .transceiver_receive_in, .ssp_slave_select_n,
		.change_interrupt_two, .change_interrupt_three, .program_clock_in, .program_data_in,
		.analog_select_a, .comparator_one_pos_pin, .pin_read_b_analog_en);
	ppm_pins i_ppm_pins (.pclk, .pa_drive, .pb_drive, .ext_a, .ext_b, .tool_en, .tool_clk,
		.pa_in, .pb_in);

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one APB transfer; holds everything until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask

	// straps are caught only just after reset, so each strap set needs one
	task automatic do_reset(input ppm_osc_e m, input logic pbad, input logic route);
		presetn <= 1'b0;
		{osc_mode_cfg, pin_read_b_analog_default, ccp_two_route_select} <= {m, pbad, route};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	initial begin
		#400000;
		n_fail++;
		finish_test();
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, tool_en, tool_clk} = '0;
		{prog_debug_enable, comparator_one_output, comparator_two_output} = '0;
		{capture_compare_two_out, capture_compare_two_oe, prog_data_out, prog_data_oe} = '0;
		{osc_mode_cfg, pin_read_b_analog_default, ccp_two_route_select} = {OSC_EXT_CLOCK_IO, 2'b11};
		{ext_a, ext_b} = '0;
		do_reset(OSC_EXT_CLOCK_IO, 1'b1, 1'b1);
		chk(pa_drive.oe, 0);
		chk(ssp_slave_select_n, 0);
		apb(0, ADDR_CONTROL, 0);
		chk(rd, 32'h1F31);
		chk({analog_select_a, comparator_one_pos_pin}, 3'h7);
		$display("test reset done");
		foreach (rows[i]) begin
			{comparator_two_output, comparator_one_output} <= rows[i].cmp;
			apb(1, ADDR_PA_LATCH, rows[i].lat);
			apb(1, ADDR_PA_DIR, rows[i].dir);
			apb(1, ADDR_CONTROL, rows[i].ctl);
			repeat (2) @(posedge pclk);
			chk({pa_drive.out & pa_drive.oe, pa_drive.oe}, rows[i].exp);
		end
		$display("test drive table done");
		{ext_a, ext_b} <= 6'h2F;
		apb(1, ADDR_PA_DIR, 32'h78);
		apb(1, ADDR_CONTROL, 32'h31);
		repeat (4) @(posedge pclk);
		apb(0, ADDR_PIN_READ, 0);
		chk(rd, 32'hC050);
		chk({timer_zero_clock_in, ssp_slave_select_n, change_interrupt_three}, 3'h5);
		apb(1, ADDR_CONTROL, 32'h08);
		repeat (4) @(posedge pclk);
		apb(0, ADDR_PIN_READ, 0);
		chk(rd, 32'hC058);
		chk(pb_drive.pull, 2'h3);
		apb(1, ADDR_PA_LATCH, 32'h10);
		apb(1, ADDR_PA_DIR, 32'h00);
		repeat (4) @(posedge pclk);
		chk({transceiver_receive_in, timer_zero_clock_in}, 2'h2);
		apb(0, 8'h1C, 0);
		chk(err, 1);
		chk(rd, 0);
		$display("test pin reads done");
		apb(1, ADDR_PB_DIR, 0);
		apb(1, ADDR_PB_LATCH, 32'hC0);
		{prog_debug_enable, tool_en, tool_clk, prog_data_out, prog_data_oe} <= 5'h1F;
		repeat (6) @(posedge pclk);
		chk({pb_drive.out & pb_drive.oe, pb_drive.oe, pb_drive.pull}, 6'h28);
		chk({program_clock_in, program_data_in, change_interrupt_two}, 3'h6);
		{prog_debug_enable, tool_en} <= 2'b00;
		repeat (6) @(posedge pclk);
		chk({pb_drive.out, pb_drive.oe}, 4'hF);
		$display("test debug done");
		for (int m = 0; m < 8; m++) begin
			do_reset(ppm_osc_e'(m), m[1], m[0]);
			{capture_compare_two_out, capture_compare_two_oe} <= 2'b11;
			apb(1, ADDR_PA_LATCH, 32'h40);
			apb(1, ADDR_PA_DIR, 0);
			repeat (2) @(posedge pclk);
			ones = 0;
			repeat (8) begin
				@(posedge pclk);
				ones += int'(pa_drive.out[IA6] & pa_drive.oe[IA6]);
			end
			chk(ones, m inside {2, 4, 5} ? 8 : m inside {1, 3, 6} ? 4 : 0);
			chk(pin_read_b_analog_en, {5{m[1]}});
			chk({ccp_two_alt_pin, ccp_two_default_pin}, m[0] ? 4'h3 : 4'hC);
			apb(1, ADDR_PA_DIR, 32'h78);
			repeat (4) @(posedge pclk);
			apb(0, ADDR_PIN_READ, 0);
			chk(rd & 32'h40, m inside {2, 4, 5} ? 32'h40 : 32'h0);
		end
		$display("test oscillator modes done");
		finish_test();
	end
endmodule
